// >>> rtl/serial_port_consts.svh
// constants of the serial port low control word block
// assumes inclusion by bare name from the design file
`ifndef SERIAL_PORT_CONSTS_SVH
`define SERIAL_PORT_CONSTS_SVH
// register byte offsets on the wishbone bus
`define OFS_CTRL_LOW    6'h00
`define OFS_CTRL_HIGH   6'h04
`define OFS_STATUS      6'h08
`define OFS_TX_LOW      6'h0c
`define OFS_TX_HIGH     6'h10
`define OFS_RX_LOW      6'h14
`define OFS_RX_HIGH     6'h18
// low control word fields
`define BIT_ON          15
`define BIT_UNUSED14    14
`define BIT_IDLE_STOP   13
`define BIT_OUT_REL     12
`define BIT_WIDE        11
`define BIT_MIDDLE      10
`define BIT_EDGE        8
`define BIT_SS_USE      7
`define BIT_POL         6
`define BIT_MCLK_SRC    2
// high control word fields
`define BIT_AUDIO       15
`define BIT_FRAMED      14
`define BIT_DSP         1
`define BIT_FSYNC_PW    0
// status word fields
`define BIT_RX_OVF      6
`define BIT_RX_FULL     0
// reset values and writable bit masks
`define CTRL_LOW_RST    16'h0000
`define CTRL_HIGH_RST   16'h0000
`define CTRL_LOW_MASK   16'hbfff
`define CTRL_HIGH_MASK  16'hc003
`endif

// >>> rtl/serial_port_control_low.sv
// serial port slave shifter steered by the low and high control words
// assumes a classic wishbone master on clk; link pins are asynchronous
//
// The implementer's own choices: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
`include "serial_port_consts.svh"

module serial_port_control_low (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [5:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        cpu_idle,
	input  wire logic        sck_in,
	input  wire logic        ss_n_in,
	input  wire logic        sdi_in,
	output logic             serial_out_pin,
	output logic             serial_out_pin_oe,
	output logic             left_right_clock
);

	////////////////////////////////////////////////////////////////////
	// decode helpers

	// data bits per word
	function automatic logic [5:0] data_bits(input logic audio,
		input logic wide, input logic middle);
		logic [5:0] n;
		n = 6'h08;
		if (!audio) begin
			n = wide ? 6'h20 : (middle ? 6'h10 : 6'h08);
		end else begin
			unique case ({wide, middle})
				2'b11: n = 6'h18;
				2'b10: n = 6'h20;
				2'b01: n = 6'h10;
				2'b00: n = 6'h10;
			endcase
		end
		return n;
	endfunction

	// bits per channel slot; equals the word in plain mode
	function automatic logic [5:0] chan_bits(input logic audio,
		input logic wide, input logic middle);
		logic [5:0] n;
		n = data_bits(audio, wide, middle);
		if (audio) begin
			n = (wide | middle) ? 6'h20 : 6'h10;
		end
		return n;
	endfunction

	////////////////////////////////////////////////////////////////////
	// registers

	logic [15:0] ctrl_low_reg;
	logic [15:0] ctrl_high_reg;
	logic [15:0] tx_low_reg;
	logic [15:0] tx_high_reg;
	logic [31:0] rx_reg;
	logic        tx_low_written_reg;
	logic        tx_high_written_reg;
	logic        rx_full_reg;
	logic        receive_overflow_flag;

	logic bus_req;
	logic bus_wr;
	logic word_done;
	logic load_word;
	assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign bus_wr  = bus_req & wb_we_i;

	logic serial_port_on;
	logic idle_stop_sel;
	logic out_pin_release;
	logic wide_word_sel;
	logic middle_word_sel;
	logic audio_protocol_on;
	logic framed_operation_on;
	logic slave_select_usage;
	logic edge_eff;
	logic dsp_mode;
	logic frame_sync_pulse_width;
	assign serial_port_on         = ctrl_low_reg[`BIT_ON];
	assign idle_stop_sel          = ctrl_low_reg[`BIT_IDLE_STOP];
	assign out_pin_release        = ctrl_low_reg[`BIT_OUT_REL];
	assign wide_word_sel          = ctrl_low_reg[`BIT_WIDE];
	assign middle_word_sel        = ctrl_low_reg[`BIT_MIDDLE];
	assign audio_protocol_on      = ctrl_high_reg[`BIT_AUDIO];
	assign framed_operation_on    = ctrl_high_reg[`BIT_FRAMED];
	assign dsp_mode               = ctrl_high_reg[`BIT_DSP];
	assign frame_sync_pulse_width = ctrl_high_reg[`BIT_FSYNC_PW];
	// audio behaves as edge select zero whatever is stored
	assign edge_eff = ctrl_low_reg[`BIT_EDGE] & ~audio_protocol_on;
	// framed mode never looks at the slave select usage bit
	assign slave_select_usage = ctrl_low_reg[`BIT_SS_USE] &
		~framed_operation_on;

	// low control word; only the lower byte lane pair matters
	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_low_reg <= `CTRL_LOW_RST;
		end else if (bus_wr && wb_adr_i == `OFS_CTRL_LOW) begin
			if (wb_sel_i[1]) begin
				ctrl_low_reg[15:8] <= wb_dat_i[15:8] &
					8'(`CTRL_LOW_MASK >> 8);
			end
			if (wb_sel_i[0]) begin
				ctrl_low_reg[7:3] <= wb_dat_i[7:3];
				ctrl_low_reg[1:0] <= wb_dat_i[1:0];
				// source select is frozen while the port runs
				if (!serial_port_on) begin
					ctrl_low_reg[`BIT_MCLK_SRC] <=
						wb_dat_i[`BIT_MCLK_SRC];
				end
			end
		end
	end

	// high control word: audio, framed, dsp format and sync width
	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_high_reg <= `CTRL_HIGH_RST;
		end else if (bus_wr && wb_adr_i == `OFS_CTRL_HIGH) begin
			if (wb_sel_i[1]) begin
				ctrl_high_reg[15:8] <= wb_dat_i[15:8] &
					8'(`CTRL_HIGH_MASK >> 8);
			end
			if (wb_sel_i[0]) begin
				ctrl_high_reg[7:0] <= wb_dat_i[7:0] &
					8'(`CTRL_HIGH_MASK);
			end
		end
	end

	// transmit halves and their written marks
	always_ff @(posedge clk) begin
		if (rst || !serial_port_on) begin
			tx_low_reg          <= 16'h0000;
			tx_high_reg         <= 16'h0000;
			tx_low_written_reg  <= 1'b0;
			tx_high_written_reg <= 1'b0;
		end else begin
			if (load_word) begin
				tx_low_written_reg  <= 1'b0;
				tx_high_written_reg <= 1'b0;
			end
			if (bus_wr && wb_adr_i == `OFS_TX_LOW) begin
				tx_low_reg         <= wb_dat_i[15:0];
				tx_low_written_reg <= 1'b1;
			end
			if (bus_wr && wb_adr_i == `OFS_TX_HIGH) begin
				tx_high_reg         <= wb_dat_i[15:0];
				tx_high_written_reg <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// link pin synchronisers

	logic [1:0] sck_sync;
	logic [1:0] ss_sync;
	logic [1:0] sdi_sync;
	logic       sck_last;
	always_ff @(posedge clk) begin
		if (rst) begin
			sck_sync <= 2'b00;
			ss_sync  <= 2'b11;
			sdi_sync <= 2'b00;
			sck_last <= 1'b0;
		end else begin
			sck_sync <= {sck_sync[0], sck_in};
			ss_sync  <= {ss_sync[0], ss_n_in};
			sdi_sync <= {sdi_sync[0], sdi_in};
			sck_last <= sck_sync[1];
		end
	end

	logic sck_lvl;
	logic lead_edge;
	logic trail_edge;
	logic launch_edge;
	logic sample_edge;
	logic selected;
	logic running;
	// idle clock level set by the polarity bit
	assign sck_lvl     = sck_sync[1] ^ ctrl_low_reg[`BIT_POL];
	assign lead_edge   = sck_lvl & ~(sck_last ^ ctrl_low_reg[`BIT_POL]);
	assign trail_edge  = ~sck_lvl & (sck_last ^ ctrl_low_reg[`BIT_POL]);
	assign launch_edge = edge_eff ? trail_edge : lead_edge;
	assign sample_edge = edge_eff ? lead_edge : trail_edge;
	assign selected    = ~slave_select_usage | ~ss_sync[1];
	// halted shifting in idle only when asked; state is kept
	assign running = serial_port_on & ~(idle_stop_sel & cpu_idle);

	////////////////////////////////////////////////////////////////////
	// shifter

	serial_port_pkg::shift_state_t state_reg;
	logic [31:0] shift_out_reg;
	logic [31:0] shift_in_reg;
	logic [5:0]  bit_cnt_reg;
	logic [5:0]  chan_cnt_reg;
	logic        chan_sel_reg;
	logic [5:0]  dbits;
	logic [5:0]  cbits;
	logic        tx_ready;
	assign dbits = data_bits(audio_protocol_on, wide_word_sel,
		middle_word_sel);
	assign cbits = chan_bits(audio_protocol_on, wide_word_sel,
		middle_word_sel);
	// audio waits for both halves, plain wide words too
	assign tx_ready = tx_low_written_reg & (tx_high_written_reg |
		~(audio_protocol_on | wide_word_sel));
	assign load_word = running && state_reg == serial_port_pkg::st_wait &&
		tx_ready && selected;
	assign word_done = running && state_reg == serial_port_pkg::st_shift &&
		sample_edge && chan_cnt_reg == cbits - 6'h01;

	// word state: off clears everything, wait for data, shift
	always_ff @(posedge clk) begin
		if (rst || !serial_port_on) begin
			state_reg     <= serial_port_pkg::st_off;
			shift_out_reg <= 32'h0000_0000;
			shift_in_reg  <= 32'h0000_0000;
			bit_cnt_reg   <= 6'h00;
			chan_cnt_reg  <= 6'h00;
			chan_sel_reg  <= 1'b0;
		end else if (running) begin
			unique case (state_reg)
				serial_port_pkg::st_off: begin
					state_reg <= serial_port_pkg::st_wait;
				end
				serial_port_pkg::st_wait: begin
					if (load_word) begin
						// msb first, left justified in the slot
						shift_out_reg <= {tx_high_reg, tx_low_reg} <<
							(6'h20 - dbits);
						bit_cnt_reg   <= 6'h00;
						chan_cnt_reg  <= 6'h00;
						state_reg     <= serial_port_pkg::st_shift;
					end
				end
				serial_port_pkg::st_shift: begin
					if (launch_edge && chan_cnt_reg != 6'h00) begin
						shift_out_reg <= {shift_out_reg[30:0], 1'b0};
					end
					if (sample_edge) begin
						if (bit_cnt_reg < dbits) begin
							shift_in_reg <= {shift_in_reg[30:0],
								sdi_sync[1]};
							bit_cnt_reg  <= bit_cnt_reg + 6'h01;
						end
						chan_cnt_reg <= chan_cnt_reg + 6'h01;
						if (word_done) begin
							chan_sel_reg <= ~chan_sel_reg;
							state_reg    <= serial_port_pkg::st_wait;
						end
					end
				end
				default: state_reg <= serial_port_pkg::st_off;
			endcase
		end
	end

	// receive word and overflow; set wins over software clear
	always_ff @(posedge clk) begin
		if (rst || !serial_port_on) begin
			rx_reg                <= 32'h0000_0000;
			rx_full_reg           <= 1'b0;
			receive_overflow_flag <= 1'b0;
		end else begin
			if (bus_req && !wb_we_i && wb_adr_i == `OFS_RX_LOW) begin
				rx_full_reg <= 1'b0;
			end
			if (bus_wr && wb_adr_i == `OFS_STATUS &&
				wb_sel_i[0] && wb_dat_i[`BIT_RX_OVF]) begin
				receive_overflow_flag <= 1'b0;
			end
			if (word_done) begin
				if (rx_full_reg) begin
					receive_overflow_flag <= 1'b1;
				end else begin
					rx_reg      <= {shift_in_reg[30:0], sdi_sync[1]};
					rx_full_reg <= 1'b1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// pin outputs

	// data out driven only while on, selected and not released
	always_ff @(posedge clk) begin
		if (rst) begin
			serial_out_pin    <= 1'b0;
			serial_out_pin_oe <= 1'b0;
		end else begin
			serial_out_pin    <= shift_out_reg[31];
			serial_out_pin_oe <= serial_port_on & ~out_pin_release &
				selected;
		end
	end

	// lr clock: channel halves, or a sync pulse in dsp format
	always_ff @(posedge clk) begin
		if (rst || !serial_port_on || !audio_protocol_on) begin
			left_right_clock <= 1'b0;
		end else if (dsp_mode) begin
			// slot length plays no part here
			left_right_clock <= state_reg == serial_port_pkg::st_shift &&
				!chan_sel_reg && (frame_sync_pulse_width ?
				bit_cnt_reg < dbits : chan_cnt_reg == 6'h00);
		end else begin
			left_right_clock <= chan_sel_reg;
		end
	end

	////////////////////////////////////////////////////////////////////
	// wishbone answer: ack one cycle after the request, then drop

	always_ff @(posedge clk) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= bus_req;
			wb_dat_o <= 32'h0000_0000;
			if (bus_req && !wb_we_i) begin
				unique case (wb_adr_i)
					// bit 14 has no storage so it reads zero
					`OFS_CTRL_LOW:  wb_dat_o <= {16'h0000,
						ctrl_low_reg & `CTRL_LOW_MASK};
					`OFS_CTRL_HIGH: wb_dat_o <= {16'h0000, ctrl_high_reg};
					`OFS_STATUS:    wb_dat_o <= {25'h0000000,
						receive_overflow_flag, 5'h00, rx_full_reg};
					`OFS_TX_LOW:    wb_dat_o <= {16'h0000, tx_low_reg};
					`OFS_TX_HIGH:   wb_dat_o <= {16'h0000, tx_high_reg};
					`OFS_RX_LOW:    wb_dat_o <= {16'h0000, rx_reg[15:0]};
					`OFS_RX_HIGH:   wb_dat_o <= {16'h0000, rx_reg[31:16]};
					default:        wb_dat_o <= 32'h0000_0000;
				endcase
			end
		end
	end

endmodule

// >>> rtl/serial_port_pkg.sv
// types of the serial port low control word block
// assumes nothing beyond a sv compiler
package serial_port_pkg;
	typedef enum logic [1:0] {
		st_off   = 2'b00,
		st_wait  = 2'b01,
		st_shift = 2'b10
	} shift_state_t;
endpackage

// >>> tb/link_peer.sv
// link peer: behavioural serial master driving clock, select and data
// assumes clock polarity 0, msb first, 320 ns link period
`timescale 1ns/1ps
module link_peer (
	output logic            sck_in,
	output logic            ss_n_in,
	output logic            sdi_in,
	input  wire logic       serial_out_pin
);
	initial begin
		sck_in = 1'b0;
		ss_n_in = 1'b1;
		sdi_in = 1'b0;
	end
	// one frame of n bits; the clock stands still outside frames
	task automatic xfer(input int n, input logic [31:0] tx,
		input logic ssh, output logic [31:0] rx);
		rx = '0;
		ss_n_in = ssh;
		// keep link edges clear of the system clock's rising edge
		#10;
		for (int i = n - 1; i >= 0; i--) begin
			#120 sdi_in = tx[i];
			#40 sck_in = 1'b1;
			#159 rx = {rx[30:0], serial_out_pin};
			#1 sck_in = 1'b0;
		end
		// released line has no pull: show the inverse, not a stale bit
		#120 sdi_in = ~sdi_in;
		ss_n_in = 1'b1;
	endtask
endmodule

// >>> tb/serial_port_chk.sv
// checker: bus handshake and pin rules of the control word block
// assumes it is bound to the design top and sees only its ports
`timescale 1ns/1ps
module serial_port_chk (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [5:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        cpu_idle,
	input wire logic        sck_in,
	input wire logic        ss_n_in,
	input wire logic        sdi_in,
	input wire logic        serial_out_pin,
	input wire logic        serial_out_pin_oe,
	input wire logic        left_right_clock
);
	logic on_sh;
	logic rel_sh;
	logic aud_sh;
	////////////////////////////////////////////////////////////////////////
	// shadow of written control bits, taken at the edge that sees ack
	always_ff @(posedge clk) begin
		if (rst) begin
			on_sh <= 1'b0;
			rel_sh <= 1'b0;
			aud_sh <= 1'b0;
		end else if (wb_ack_o && wb_we_i && wb_sel_i[1]) begin
			if (wb_adr_i == 6'h00) begin
				on_sh <= wb_dat_i[15];
				rel_sh <= wb_dat_i[12];
			end
			if (wb_adr_i == 6'h04)
				aud_sh <= wb_dat_i[15];
		end
	end
	////////////////////////////////////////////////////////////////////////
	// three clean samples give the registered pins time to follow
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_take;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_rd_ctrl;
		wb_ack_o && !wb_we_i && wb_adr_i == 6'h00;
	endsequence
	a_take_ack: assert property (s_take |=> wb_ack_o)
		else $error("request not acked in the next cycle");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without a request");
	a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside ack");
	a_bit14_zero: assert property (s_rd_ctrl |->
		wb_dat_o[31:16] == 16'h0 && !wb_dat_o[14])
		else $error("unused control bit reads nonzero");
	a_unmapped_zero: assert property (wb_ack_o && !wb_we_i &&
		wb_adr_i > 6'h18 |-> wb_dat_o == 32'h0)
		else $error("unmapped read nonzero");
	a_oe_off: assert property (!on_sh [*3] |-> !serial_out_pin_oe)
		else $error("data out driven while port off");
	a_oe_release: assert property (rel_sh [*3] |-> !serial_out_pin_oe)
		else $error("data out driven while released");
	a_lrc_plain: assert property (!aud_sh [*3] |-> !left_right_clock)
		else $error("channel clock active outside audio");
endmodule

// >>> tb/tb_top.sv
// testbench top: register and link scenarios for the control word block
// assumes design, checker and link peer are compiled before this file
`timescale 1ns/1ps
module tb_top;
	logic        clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, cpu_idle;
	logic [5:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, q;
	logic        wb_ack_o, sck_in, ss_n_in, sdi_in;
	logic        serial_out_pin, serial_out_pin_oe, left_right_clock;
	int          fail_count, n_tests;
	serial_port_control_low serial_port_control_low_inst (.clk, .rst,
		.wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
		.wb_dat_o, .wb_ack_o, .cpu_idle, .sck_in, .ss_n_in, .sdi_in,
		.serial_out_pin, .serial_out_pin_oe, .left_right_clock);
	link_peer link_peer_inst (.sck_in, .ss_n_in, .sdi_in, .serial_out_pin);
	////////////////////////////////////////////////////////////////////////
	always #20 clk = ~clk;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// classic cycle: hold everything until ack is sampled high
	task automatic wb(input logic we, input logic [5:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hf;
		do begin
			@(posedge clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 40);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (n >= 40)
			chk(32'h1, 32'h0);
	endtask
	task automatic rd(input logic [5:0] a, input logic [31:0] exp);
		wb(1'b0, a, 32'h0);
		chk(q, exp);
	endtask
	// one full-duplex word; both directions compared, then port off
	task automatic run_word(input logic [15:0] cl, input int n,
		input logic ssh);
		logic [31:0] got, exp, sent;
		sent = 32'h3c5a96e1 & ~(32'hffffffff << n);
		exp = 32'hd2b47e19 & ~(32'hffffffff << n);
		wb(1'b1, 6'h00, {16'h0, cl});
		wb(1'b1, 6'h0c, {16'h0, exp[15:0]});
		wb(1'b1, 6'h10, {16'h0, exp[31:16]});
		repeat (4) @(posedge clk);
		link_peer_inst.xfer(n, sent, ssh, got);
		chk(got, exp);
		repeat (6) @(posedge clk);
		rd(6'h14, {16'h0, sent[15:0]});
		if (n == 32)
			rd(6'h18, {16'h0, sent[31:16]});
		wb(1'b1, 6'h00, 32'h0);
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_regs;
		rd(6'h00, 32'h0);
		rd(6'h3c, 32'h0);
		wb(1'b1, 6'h00, 32'hffff);
		rd(6'h00, 32'hbfff);
		wb(1'b1, 6'h00, 32'h8000);
		rd(6'h00, 32'h8004);
		wb(1'b1, 6'h00, 32'h0);
		rd(6'h00, 32'h0004);
		wb(1'b1, 6'h00, 32'h0);
		rd(6'h00, 32'h0);
		$display("test regs done");
	endtask
	task automatic t_release;
		wb(1'b1, 6'h00, 32'h8000);
		repeat (4) @(posedge clk);
		chk({31'h0, serial_out_pin_oe}, 32'h1);
		wb(1'b1, 6'h00, 32'h9000);
		repeat (4) @(posedge clk);
		chk({31'h0, serial_out_pin_oe}, 32'h0);
		wb(1'b1, 6'h00, 32'h0);
		repeat (4) @(posedge clk);
		chk({31'h0, serial_out_pin_oe}, 32'h0);
		$display("test release done");
	endtask
	task automatic t_plain;
		cpu_idle <= 1'b1;
		run_word(16'h8000, 8, 1'b0);
		run_word(16'h8400, 16, 1'b0);
		run_word(16'h8800, 32, 1'b0);
		run_word(16'h8c00, 32, 1'b0);
		cpu_idle <= 1'b0;
		$display("test plain lengths done");
	endtask
	task automatic t_framed;
		wb(1'b1, 6'h04, 32'h4000);
		run_word(16'h8480, 16, 1'b1);
		wb(1'b1, 6'h04, 32'h0);
		$display("test framed done");
	endtask
	task automatic t_audio;
		wb(1'b1, 6'h04, 32'h8000);
		wb(1'b1, 6'h08, 32'h40);
		run_word(16'h8100, 16, 1'b0);
		run_word(16'h8900, 32, 1'b0);
		wb(1'b1, 6'h04, 32'h0);
		$display("test audio done");
	endtask
	task automatic t_idle;
		logic [31:0] got;
		cpu_idle <= 1'b1;
		wb(1'b1, 6'h00, 32'ha000);
		wb(1'b1, 6'h0c, 32'h00a5);
		repeat (4) @(posedge clk);
		link_peer_inst.xfer(8, 32'h5a, 1'b0, got);
		repeat (6) @(posedge clk);
		rd(6'h08, 32'h0);
		cpu_idle <= 1'b0;
		wb(1'b1, 6'h00, 32'h0);
		$display("test idle stop done");
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 6'h00;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h0;
		cpu_idle = 1'b0;
		fail_count = 0;
		n_tests = 0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		t_regs;
		t_release;
		t_plain;
		t_framed;
		t_audio;
		t_idle;
		wrap_up;
	end
	// watchdog: the whole run needs well under a millisecond
	initial begin
		#1000000;
		fail_count++;
		wrap_up;
	end
endmodule
bind serial_port_control_low serial_port_chk serial_port_chk_inst (.clk,
	.rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
	.wb_dat_o, .wb_ack_o, .cpu_idle, .sck_in, .ss_n_in, .sdi_in,
	.serial_out_pin, .serial_out_pin_oe, .left_right_clock);
